// *** sim/ssc_master_model.sv ***
// Behavioural two-wire bus master standing in for the host processor.
// Assumes the bench resolves the open-drain data line with a pull-up.
module ssc_master_model (
    // Pacing clock
    input  wire logic       sys_clk,
    // Bus
    input  wire logic       sda_line,
    output logic            scl,
    output logic            sda_low,
    // Last byte or acknowledge seen
    output logic [7:0]      got_val
);
    timeunit 1ns;
    timeprecision 1ns;
    event got;

    // Clock stands high between frames
    initial begin
        scl     = 1'b1;
        sda_low = 1'b0;
        got_val = 8'h00;
    end

    // ============================================================
    // Bit and frame helpers
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : tick

    // Data moves late in the low phase, after the slave has let go of its bit
    task automatic bit_io(input logic b, output logic s);
        tick(8);
        sda_low = !b;
        tick(4);
        scl = 1'b1;
        tick(7);
        s = sda_line;
        tick(1);
        scl = 1'b0;
    endtask : bit_io

    // From idle a plain start, inside a frame a repeated start
    task automatic start();
        if (!scl) begin
            tick(8);
            sda_low = 1'b0;
            tick(4);
            scl = 1'b1;
            tick(8);
        end
        sda_low = 1'b1;
        tick(8);
        scl = 1'b0;
    endtask : start

    task automatic stop();
        tick(8);
        sda_low = 1'b1;
        tick(4);
        scl = 1'b1;
        tick(8);
        sda_low = 1'b0;
        tick(8);
    endtask : stop

    // Byte MSB first, then the ninth bit; a read ends on NACK
    task automatic xfer(input logic [7:0] tx, input logic rd, input logic nack);
        logic [7:0] rx;
        logic       s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], s);
            rx[i] = s;
        end
        bit_io(rd ? nack : 1'b1, s);
        got_val = rd ? rx : {7'h00, s};
        -> got;
    endtask : xfer
endmodule : ssc_master_model

// *** sim/ssc_port_chk.sv ***
// Pin-level checker for the configuration slave port.
// Assumes it sees only the top ports; bound into every ssc_port below.
module ssc_port_chk
    import ssc_pkg::*;
#(
    parameter int EVENTS = DATA_BITS
)
(
    // Clock and reset
    input wire logic              sys_clk,
    input wire logic              reset_n,
    input wire logic              clk_en,
    // Bus pins
    input wire logic              scl_in,
    input wire logic              sda_in,
    input wire logic              sda_out,
    input wire logic              sda_oe,
    // Straps, events and interrupt
    input wire logic              base_select_pin,
    input wire logic              addr_lsb_select_pin,
    input wire logic              hub_init,
    input wire logic [EVENTS-1:0] event_in,
    input wire logic              int_n
);
    timeunit 1ns;
    timeprecision 1ns;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    // ============================================================
    // Bus watch at pin level
    logic       scl_q;
    logic       sda_q;
    logic       busy;
    logic       seen_evt;
    logic [3:0] rises;
    logic [3:0] quiet;
    logic       start_seen;
    logic       stop_seen;

    assign start_seen = scl_in && scl_q && sda_q && !sda_in;
    assign stop_seen  = scl_in && scl_q && !sda_q && sda_in;

    // Quiet counts cycles with no event and no clock edge; writes land well before it hits 10
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            scl_q    <= 1'b1;
            sda_q    <= 1'b1;
            busy     <= 1'b0;
            seen_evt <= 1'b0;
            rises    <= 4'h0;
            quiet    <= 4'h0;
        end else begin
            scl_q    <= scl_in;
            sda_q    <= sda_in;
            busy     <= start_seen || (busy && !stop_seen);
            seen_evt <= seen_evt || (|event_in);
            rises    <= start_seen ? 4'h0 : rises + {3'h0, scl_in && !scl_q && rises != 4'hF};
            quiet    <= ((|event_in) || scl_in != scl_q) ? 4'h0 : quiet + {3'h0, quiet != 4'hF};
        end
    end

    // ============================================================
    // Assertions
    od_low_a: assert property (
        sda_oe |-> !sda_out) else $error("Data line driven high");
    oe_scl_low_a: assert property (
        $changed(sda_oe) |-> !scl_in) else $error("Data drive moved while clock high");
    oe_busy_a: assert property (
        sda_oe |-> busy) else $error("Data line driven outside a frame");
    start_quiet_a: assert property (
        start_seen |-> !sda_oe [*8]) else $error("Data line driven during address bits");
    ack_after8_a: assert property (
        $rose(sda_oe) |-> rises >= 4'h8) else $error("Acknowledge before eight bits");
    int_rst_a: assert property (
        $rose(reset_n) |-> int_n) else $error("Interrupt low straight after reset");
    int_cause_a: assert property (
        $fell(int_n) |-> seen_evt) else $error("Interrupt low without any event");
    int_quiet_a: assert property (
        quiet >= 4'hA |-> $stable(int_n)) else $error("Interrupt moved with no cause");
endmodule : ssc_port_chk

bind ssc_port ssc_port_chk #(.EVENTS(EVENTS)) i_chk (
    .sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en), .scl_in(scl_in),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .base_select_pin(base_select_pin),
    .addr_lsb_select_pin(addr_lsb_select_pin), .hub_init(hub_init), .event_in(event_in),
    .int_n(int_n)
);

// *** sim/ssc_port_tb_top.sv ***
// Self-checking bench for the configuration slave port.
// Assumes the master model paces the bus from the system clock.
module ssc_port_tb_top
    import ssc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic       sys_clk;
    logic       reset_n;
    logic       clk_en;
    logic       scl;
    logic       sda_low;
    logic       sda_line;
    logic       sda_out;
    logic       sda_oe;
    logic       bsel;
    logic       lsel;
    logic       hub_init;
    logic [7:0] event_in;
    logic       int_n;
    logic [7:0] got_val;
    logic [8:0] exp_q[$];
    logic [8:0] exp_now;
    logic [7:0] ra;
    logic [7:0] rb;
    logic [7:0] mk;
    logic [6:0] dev;
    int         err_count = 0;
    int         n_compared = 0;

    // Pull-up on the data line; either party may pull it low
    assign sda_line = !(sda_low || (sda_oe && !sda_out));

    ssc_port i_dut (
        .sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .base_select_pin(bsel), .addr_lsb_select_pin(lsel),
        .hub_init(hub_init), .event_in(event_in), .int_n(int_n)
    );
    ssc_master_model i_master (
        .sys_clk(sys_clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low), .got_val(got_val)
    );

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk; // Kept running while the port is used
    end

    // ============================================================
    // Scoreboard and closing
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        n_compared++;
        if (seen !== want) begin
            err_count++;
            $display("BAD %0t: saw %h, expected %h", $time, seen, want);
        end
    endtask : check

    // Bit 8 of a note marks a result that is not judged
    always @(i_master.got) begin
        exp_now = exp_q.pop_front();
        if (!exp_now[8]) begin
            check(got_val, exp_now[7:0]);
        end
    end

    task automatic end_of_test();
        $display("Compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test

    initial begin
        #9000000;
        err_count++;
        $display("BAD %0t: watchdog expired", $time);
        end_of_test();
    end

    // ============================================================
    // Bus and pin tasks
    task automatic head(input logic [7:0] ptr);
        i_master.start();
        exp_q.push_back(9'h000);
        i_master.xfer({dev, 1'b0}, 1'b0, 1'b0);
        exp_q.push_back(9'h000);
        i_master.xfer(ptr, 1'b0, 1'b0);
    endtask : head

    task automatic wr(input logic [7:0] ptr, input logic [7:0] d[$], input logic [8:0] tail);
        head(ptr);
        foreach (d[i]) begin
            exp_q.push_back(i == d.size() - 1 ? tail : 9'h000);
            i_master.xfer(d[i], 1'b0, 1'b0);
        end
        i_master.stop();
    endtask : wr

    task automatic rd(input logic [7:0] ptr, input logic [7:0] e[$], input logic sr);
        head(ptr);
        if (!sr) begin
            i_master.stop();
        end
        i_master.start();
        exp_q.push_back(9'h000);
        i_master.xfer({dev, 1'b1}, 1'b0, 1'b0);
        foreach (e[i]) begin
            exp_q.push_back({1'b0, e[i]});
            i_master.xfer(8'hFF, 1'b1, i == e.size() - 1);
        end
        i_master.stop();
    endtask : rd

    task automatic probe(input logic [6:0] a);
        i_master.start();
        exp_q.push_back(9'h001);
        i_master.xfer({a, 1'b0}, 1'b0, 1'b0);
        i_master.stop();
    endtask : probe

    task automatic strap(input logic b, input logic l);
        @(negedge sys_clk);
        bsel = b;
        lsel = l;
        hub_init = 1'b1;
        repeat (10) @(negedge sys_clk);
        hub_init = 1'b0;
    endtask : strap

    task automatic pulse(input logic [7:0] v, input logic want);
        @(negedge sys_clk);
        event_in = v;
        @(negedge sys_clk);
        event_in = 8'h00;
        repeat (4) @(negedge sys_clk);
        check({7'h00, int_n}, {7'h00, want});
    endtask : pulse

    // ============================================================
    // Main sequence
    initial begin
        reset_n  = 1'b0;
        clk_en   = 1'b1;
        bsel     = 1'b0;
        lsel     = 1'b0;
        hub_init = 1'b1;
        event_in = 8'h00;
        ra       = 8'($urandom(32'hDB983BFC));
        repeat (2) @(negedge sys_clk);
        reset_n = 1'b1;
        strap(1'b0, 1'b0);
        dev = {BASE_ADDR_A_RESET[6:1], 1'b0};
        rd(REG_INT_STATUS, '{REG_RESET, REG_RESET, BASE_ADDR_A_RESET, BASE_ADDR_B_RESET}, 1'b1);
        rd(REG_STATUS_COMMAND, '{STATUS_CMD_RESET, REG_RESET}, 1'b0);
        $display("test defaults done");

        ra[5] = 1'b1;
        rb    = ra ^ 8'h42;
        wr(REG_BASE_ADDR_A, '{ra, rb}, 9'h000);
        for (int k = 0; k < 4; k++) begin
            strap(k[1], k[0]);
            dev = {k[1] ? rb[6:1] : ra[6:1], k[0]};
            probe({dev[6:1], !dev[0]});
            probe({k[1] ? ra[6:1] : rb[6:1], k[0]});
            rd(REG_BASE_ADDR_A, '{ra, rb}, k[0]);
        end
        $display("test address select done");

        mk = 8'h01 << $urandom_range(7, 1);
        wr(REG_INT_MASK, '{8'hFE}, 9'h000);
        pulse(mk, 1'b1);
        rd(REG_INT_STATUS, '{mk}, 1'b1);
        pulse(8'h01, 1'b0);
        wr(REG_INT_STATUS, '{8'h01}, 9'h000);
        pulse(8'h00, 1'b1);
        wr(REG_INT_MASK, '{8'h00}, 9'h000);
        pulse(8'h00, 1'b0);
        wr(REG_INT_STATUS, '{mk}, 9'h000);
        pulse(8'h00, 1'b1);
        // A frozen core must not catch an event, so nothing is left pending
        @(negedge sys_clk);
        clk_en = 1'b0;
        pulse(8'h01, 1'b1);
        clk_en = 1'b1;
        pulse(8'h00, 1'b1);
        $display("test interrupt done");

        wr(8'h00, '{8'hA5}, 9'h000);
        wr(8'hF0, '{8'h5A}, 9'h000);
        wr(REG_INT_MASK, '{mk}, 9'h000);
        wr(REG_STATUS_COMMAND, '{8'h02}, 9'h100); // Reserved bits left zero
        rd(REG_STATUS_COMMAND, '{8'h00, 8'h00}, 1'b1);
        rd(8'hF0, '{8'h00}, 1'b0);
        rd(REG_INT_MASK, '{mk, ra, rb}, 1'b1);
        $display("test soft reset done");

        wr(8'h00, '{8'h33}, 9'h000);
        wr(REG_STATUS_COMMAND, '{8'h01}, 9'h000);
        wr(8'hFE, '{8'h44, 8'h00, 8'h44}, 9'h000);
        rd(8'hFE, '{8'h00, 8'h01, 8'h33}, 1'b1);
        wr(REG_INT_MASK, '{8'h0F}, 9'h000);
        rd(REG_INT_MASK, '{8'h0F}, 1'b0);
        @(negedge sys_clk);
        reset_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        reset_n = 1'b1;
        strap(1'b0, 1'b0);
        dev = {BASE_ADDR_A_RESET[6:1], 1'b0};
        rd(REG_STATUS_COMMAND, '{STATUS_CMD_RESET}, 1'b0);
        $display("test protect done");
        check(8'(exp_q.size()), 8'h00);
        end_of_test();
    end
endmodule : ssc_port_tb_top

// *** verilog/ssc_i2c_phy.sv ***
// Bit engine of the configuration slave: conditions, shifting, acknowledge.
// Assumes scl and sda on the link are already synchronised and debounced.
module ssc_i2c_phy
    import ssc_pkg::*;
(
    // Clocking and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // Link to the register core
    ssc_link_if.phy  link
);

    ssc_phy_state_t state, next_state;
    logic [3:0]     cnt, next_cnt;
    logic [7:0]     shreg, next_shreg;
    logic           rw, next_rw;
    logic           drive, next_drive;
    logic           scl_q, sda_q;
    logic           start, stop, rise, fall;

    // Edges are judged against the last sampled level only, so the engine
    // keeps up at the bench's 500 kHz bus rate given a 10 MHz system clock.
    assign start = link.scl & scl_q & sda_q & ~link.sda;
    assign stop  = link.scl & scl_q & ~sda_q & link.sda;
    assign rise  = link.scl & ~scl_q;
    assign fall  = ~link.scl & scl_q;

    assign link.drive_low = drive;
    assign link.wr_data   = shreg;

    // ==========================================================
    // Next-state logic
    always_comb begin
        next_state    = state;
        next_cnt      = cnt;
        next_shreg    = shreg;
        next_rw       = rw;
        next_drive    = drive;
        link.start    = 1'b0;
        link.wr_valid = 1'b0;
        link.rd_adv   = 1'b0;
        if (link.soft_rst || stop) begin
            next_state = PHY_IDLE;
            next_drive = 1'b0;
        end else if (start) begin
            next_state = PHY_ADDR;
            next_cnt   = 4'h0;
            next_drive = 1'b0;
            link.start = 1'b1;
        end else begin
            unique case (state)
                PHY_IDLE: ;
                PHY_ADDR, PHY_WRITE: begin
                    if (rise) begin
                        next_shreg = {shreg[6:0], link.sda};
                        next_cnt   = cnt + 4'h1;
                    end else if (fall && cnt == BITS_PER_BYTE) begin
                        if (state == PHY_WRITE) begin
                            link.wr_valid = 1'b1;
                            next_drive    = 1'b1;
                            next_state    = PHY_WRITE_ACK;
                        end else if (shreg[7:1] == link.slave_addr) begin
                            next_rw    = shreg[0];
                            next_drive = 1'b1;
                            next_state = PHY_ADDR_ACK;
                        end else begin
                            next_state = PHY_IDLE;
                        end
                    end
                end
                PHY_ADDR_ACK: begin
                    if (fall && rw) begin
                        next_shreg  = link.tx_data;
                        next_drive  = ~link.tx_data[7];
                        link.rd_adv = 1'b1;
                        next_cnt    = 4'h0;
                        next_state  = PHY_READ;
                    end else if (fall) begin
                        next_drive = 1'b0;
                        next_cnt   = 4'h0;
                        next_state = PHY_WRITE;
                    end
                end
                PHY_WRITE_ACK: begin
                    if (fall) begin
                        next_drive = 1'b0;
                        next_cnt   = 4'h0;
                        next_state = PHY_WRITE;
                    end
                end
                PHY_READ: begin
                    if (rise) begin
                        next_cnt = cnt + 4'h1;
                    end else if (fall && cnt == BITS_PER_BYTE) begin
                        next_drive = 1'b0;
                        next_state = PHY_READ_ACK;
                    end else if (fall) begin
                        next_shreg = {shreg[6:0], 1'b0};
                        next_drive = ~shreg[6];
                    end
                end
                PHY_READ_ACK: begin
                    // A NACK ends the read; wait for stop or a new start
                    if (rise) begin
                        next_state = link.sda ? PHY_IDLE : PHY_ADDR_ACK;
                    end
                end
                default: next_state = PHY_IDLE;
            endcase
        end
    end

    // ==========================================================
    // State registers
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= PHY_IDLE;
            cnt   <= 4'h0;
            shreg <= 8'h00;
            rw    <= 1'b0;
            drive <= 1'b0;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else if (clk_en) begin
            state <= next_state;
            cnt   <= next_cnt;
            shreg <= next_shreg;
            rw    <= next_rw;
            drive <= next_drive;
            scl_q <= link.scl;
            sda_q <= link.sda;
        end
    end

endmodule : ssc_i2c_phy

// *** verilog/ssc_link_if.sv ***
// Byte-level link between the bit engine and the register core.
// Assumes both ends run on the same clock and clock enable.
interface ssc_link_if;
    logic       scl;         // Synchronised clock line level
    logic       sda;         // Synchronised data line level
    logic [6:0] slave_addr;  // Functional 7-bit address
    logic       soft_rst;    // Return the engine to idle
    logic [7:0] tx_data;     // Byte at the current pointer
    logic       start;       // Start or repeated start seen
    logic       wr_valid;    // Received data byte
    logic [7:0] wr_data;
    logic       rd_adv;      // tx_data taken for sending
    logic       drive_low;   // Request to pull data line low

    modport phy  (input  scl, sda, slave_addr, soft_rst, tx_data,
                  output start, wr_valid, wr_data, rd_adv, drive_low);
    modport core (output scl, sda, slave_addr, soft_rst, tx_data,
                  input  start, wr_valid, wr_data, rd_adv, drive_low);
endinterface : ssc_link_if

// *** verilog/ssc_pkg.sv ***
// Shared constants and types for the serial configuration slave port.
// Assumes one system clock domain; bus pins are synchronised in the top.
package ssc_pkg;

    // ==========================================================
    // Register map
    localparam logic [7:0] REG_INT_STATUS     = 8'hE8;
    localparam logic [7:0] REG_INT_MASK       = 8'hE9;
    localparam logic [7:0] REG_BASE_ADDR_A    = 8'hEA;
    localparam logic [7:0] REG_BASE_ADDR_B    = 8'hEB;
    localparam logic [7:0] REG_STATUS_COMMAND = 8'hFF;
    localparam logic [7:0] PROT_LOW_LAST      = 8'hE1;
    localparam logic [7:0] PROT_HIGH_FIRST    = 8'hEF;

    // ==========================================================
    // Fields and reset values
    localparam int         SC_PROTECT_BIT     = 0;
    localparam int         SC_SOFT_RESET_BIT  = 1;
    localparam logic [7:0] STATUS_CMD_RESET   = 8'h00;
    localparam logic [7:0] REG_RESET          = 8'h00;
    localparam logic [7:0] BASE_ADDR_A_RESET  = 8'h10;
    localparam logic [7:0] BASE_ADDR_B_RESET  = 8'h50;
    localparam int         DATA_BITS          = 8;
    localparam logic [3:0] BITS_PER_BYTE      = 4'h8;

    // ==========================================================
    // Bit-level engine states
    typedef enum logic [2:0] {
        PHY_IDLE      = 3'b000,
        PHY_ADDR      = 3'b001,
        PHY_ADDR_ACK  = 3'b010,
        PHY_WRITE     = 3'b011,
        PHY_WRITE_ACK = 3'b100,
        PHY_READ      = 3'b101,
        PHY_READ_ACK  = 3'b110
    } ssc_phy_state_t;

endpackage : ssc_pkg

// *** verilog/ssc_port.sv ***
// Top of the serial configuration slave port: pins, register file, interrupt.
// Assumes sys_clk is the running reference clock and straps are stable
// while hub_init is high.

module ssc_port
    import ssc_pkg::*;
#(
    parameter logic [7:0] BASE_A_DEFAULT = BASE_ADDR_A_RESET,
    parameter logic [7:0] BASE_B_DEFAULT = BASE_ADDR_B_RESET,
    parameter int         EVENTS         = DATA_BITS
)
(
    // Clocking and reset
    input  wire logic              sys_clk,
    input  wire logic              reset_n,
    input  wire logic              clk_en,
    // Two-wire bus, open drain
    input  wire logic              scl_in,
    input  wire logic              sda_in,
    output logic                   sda_out,
    output logic                   sda_oe,
    // Straps, hub control and events
    input  wire logic              base_select_pin,
    input  wire logic              addr_lsb_select_pin,
    input  wire logic              hub_init,
    input  wire logic [EVENTS-1:0] event_in,
    // Interrupt
    output logic                   int_n
);

    ssc_link_if link ();

    logic [3:0] pin_raw, sync1, sync2, sync3, pin_clean;
    logic [7:0] regs [256];
    logic [7:0] next_regs [256];
    logic [7:0] ptr, next_ptr;
    logic       expect_ptr, next_expect_ptr;
    logic       protect, next_protect;
    logic       srst, next_srst;
    logic       base_sel, next_base_sel;
    logic       lsb_sel, next_lsb_sel;
    logic       next_int_n;
    logic [7:0] irq_status, irq_mask, base_reg;

    function automatic logic is_protected(input logic [7:0] a);
        return (a <= PROT_LOW_LAST) || (a >= PROT_HIGH_FIRST);
    endfunction : is_protected

    function automatic logic [7:0] reg_default(input logic [7:0] a);
        if (a == REG_BASE_ADDR_A) begin
            return BASE_A_DEFAULT;
        end else if (a == REG_BASE_ADDR_B) begin
            return BASE_B_DEFAULT;
        end
        return REG_RESET;
    endfunction : reg_default

    // ==========================================================
    // Pin synchronisers: a level counts once stages two and three agree
    assign pin_raw = {scl_in, sda_in, base_select_pin, addr_lsb_select_pin};

    for (genvar g = 0; g < 4; g++) begin : g_sync
        always_ff @(posedge sys_clk or negedge reset_n) begin
            if (!reset_n) begin
                sync1[g]     <= 1'b1;
                sync2[g]     <= 1'b1;
                sync3[g]     <= 1'b1;
                pin_clean[g] <= 1'b1;
            end else if (clk_en) begin
                sync1[g] <= pin_raw[g];
                sync2[g] <= sync1[g];
                sync3[g] <= sync2[g];
                if (sync2[g] == sync3[g]) begin
                    pin_clean[g] <= sync3[g];
                end
            end
        end
    end

    // ==========================================================
    // Link wiring
    assign irq_status = regs[REG_INT_STATUS];
    assign irq_mask   = regs[REG_INT_MASK];
    assign base_reg   = base_sel ? regs[REG_BASE_ADDR_B] : regs[REG_BASE_ADDR_A];

    assign link.scl        = pin_clean[3];
    assign link.sda        = pin_clean[2];
    assign link.slave_addr = {base_reg[6:1], lsb_sel};
    assign link.soft_rst   = srst;
    // Reserved and self-clearing bits read as zero
    assign link.tx_data    = (ptr == REG_STATUS_COMMAND) ?
                             {6'h00, srst, protect} : regs[ptr];

    ssc_i2c_phy u_phy (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .clk_en  (clk_en),
        .link    (link)
    );

    // ==========================================================
    // Register core next values
    always_comb begin
        next_regs       = regs;
        next_ptr        = ptr;
        next_expect_ptr = expect_ptr;
        next_protect    = protect;
        next_srst       = 1'b0;
        next_base_sel   = base_sel;
        next_lsb_sel    = lsb_sel;
        if (hub_init) begin
            next_base_sel = pin_clean[1];
            next_lsb_sel  = pin_clean[0];
        end
        if (link.start) begin
            next_expect_ptr = 1'b1;
        end
        if (link.wr_valid && expect_ptr) begin
            next_ptr        = link.wr_data;
            next_expect_ptr = 1'b0;
        end else if (link.wr_valid) begin
            next_ptr = ptr + 8'h01;
            // Locked bytes are still acknowledged by the engine
            if (!(protect && is_protected(ptr))) begin
                if (ptr == REG_STATUS_COMMAND) begin
                    next_protect = protect | link.wr_data[SC_PROTECT_BIT];
                    next_srst    = link.wr_data[SC_SOFT_RESET_BIT];
                end else if (ptr == REG_INT_STATUS) begin
                    next_regs[ptr] = irq_status & ~link.wr_data;
                end else begin
                    next_regs[ptr] = link.wr_data;
                end
            end
        end
        if (link.rd_adv) begin
            next_ptr = ptr + 8'h01;
        end
        // A new event wins over a clear in the same cycle, masked or not
        next_regs[REG_INT_STATUS] = next_regs[REG_INT_STATUS] | event_in;
        if (srst) begin
            // The pending bit itself drops here; protect survives
            for (int i = 0; i < 256; i++) begin
                if (is_protected(8'(i))) begin
                    next_regs[i] = reg_default(8'(i));
                end
            end
            next_ptr        = 8'h00;
            next_expect_ptr = 1'b0;
        end
        next_int_n = ~|(irq_status & ~irq_mask);
    end

    // ==========================================================
    // Register core state
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < 256; i++) begin
                regs[i] <= reg_default(8'(i));
            end
            ptr        <= 8'h00;
            expect_ptr <= 1'b0;
            protect    <= STATUS_CMD_RESET[SC_PROTECT_BIT];
            srst       <= STATUS_CMD_RESET[SC_SOFT_RESET_BIT];
            base_sel   <= 1'b0;
            lsb_sel    <= 1'b0;
            int_n      <= 1'b1;
            sda_oe     <= 1'b0;
            sda_out    <= 1'b0;
        end else if (clk_en) begin
            regs       <= next_regs;
            ptr        <= next_ptr;
            expect_ptr <= next_expect_ptr;
            protect    <= next_protect;
            srst       <= next_srst;
            base_sel   <= next_base_sel;
            lsb_sel    <= next_lsb_sel;
            int_n      <= next_int_n;
            // Open drain: only ever pulls low, one cycle behind the engine
            sda_oe     <= link.drive_low;
            sda_out    <= 1'b0;
        end
    end

endmodule : ssc_port
